//--- core/gtd_cfg.svh
// Constants of the gain trim and decimation filter: offsets, fields, resets, limits.
// Assumes inclusion by the package, the filter core and the port checker.
`ifndef GTD_CFG_SVH
`define GTD_CFG_SVH

// ----------------------------------------------------------------------------
// Register map (index times four is the byte address)
// ----------------------------------------------------------------------------
`define GTD_IDX_GAIN 8'h27
`define GTD_IDX_FILT 8'h29
`define GTD_IDX_STAT 8'h2A
`define GTD_ADDR_W 12

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define GTD_GAIN_W 10
`define GTD_GAIN_RST 10'h200
`define GTD_GAIN_UNITY 11'sh200
`define GTD_GAIN_FRAC 15
`define GTD_RATE_HI 6
`define GTD_RATE_LO 3
`define GTD_FSEL_HI 1
`define GTD_FSEL_LO 0
`define GTD_FILT_RST 8'h00

// ----------------------------------------------------------------------------
// Filter limits
// ----------------------------------------------------------------------------
`define GTD_SAMPLE_W 20
`define GTD_ACC_W 64
`define GTD_LOG2_MAX_S1 4'd10
`define GTD_LOG2_MAX_S5 4'd8
`define GTD_WARM_S5 3'd4
`define GTD_WARM_COMP 3'd5
`define GTD_FIFO_DEPTH 8
`define GTD_FIFO_SLACK 4

`endif

//--- core/gtd_pkg.sv
// Types shared by the filter core and its bench modules.
// Assumes gtd_cfg.svh is on the include path.
`include "gtd_cfg.svh"

package gtd_pkg;

  // ----------------------------------------------------------------------------
  // Sample carrier and filter selection
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [`GTD_SAMPLE_W-1:0] data;
  } gtd_sample_t;

  typedef enum logic [1:0] {
    GTD_FILT_OFF = 2'h0,
    GTD_FILT_SINC1 = 2'h1,
    GTD_FILT_SINC5 = 2'h2,
    GTD_FILT_COMP = 2'h3
  } gtd_fsel_t;

  typedef enum logic [1:0] {
    GTD_REG_NONE,
    GTD_REG_GAIN,
    GTD_REG_FILT,
    GTD_REG_STAT
  } gtd_reg_t;

endpackage

//--- core/gtd_fifo.sv
// Result FIFO: width and depth parameters, valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset; read data is registered.
`timescale 1ns/1ps
`default_nettype none

module gtd_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [AW:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } st_t;

  st_t s_q, s_d;
  logic push, pop, load;

  always_comb begin
    s_d = s_q;
    // Output register is not counted in cnt; it reloads from memory when taken or empty
    load = (s_q.cnt != '0) && (!s_q.ov || out_ready);
    push = in_valid && (s_q.cnt != (AW+1)'(DEPTH));
    pop = load;
    if (out_ready && s_q.ov) begin
      s_d.ov = 1'b0;
    end
    if (load) begin
      s_d.ov = 1'b1;
      s_d.od = s_q.mem[s_q.rp];
      s_d.rp = AW'(s_q.rp + AW'(1));
    end
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = AW'(s_q.wp + AW'(1));
    end
    s_d.cnt = (AW+1)'(s_q.cnt + (AW+1)'(push) - (AW+1)'(pop));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = s_q.ov;
  assign out_data = s_q.od;
  assign level = s_q.cnt;

endmodule

`default_nettype wire

//--- core/gtd_filter.sv
// Gain trim and decimation filter core with its APB register slave.
// Assumes an APB master on pclk, a converter stream that honours in_ready,
// and a filter sync pulse from the host after each change of filter type.
`timescale 1ns/1ps
`default_nettype none
`include "gtd_cfg.svh"

module gtd_filter
  import gtd_pkg::*;
#(
  parameter int FIFO_DEPTH = `GTD_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`GTD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Filter sync pin, one-cycle active-high pulse
  input wire logic filter_sync,
  // Converter samples in
  input wire gtd_sample_t sample_in,
  output logic sample_in_ready,
  // Filtered results out
  output gtd_sample_t result_out,
  input wire logic result_out_ready
);

  localparam int SW = `GTD_SAMPLE_W;
  localparam int AW = `GTD_ACC_W;
  localparam int LW = $clog2(FIFO_DEPTH);
  // Reset image of the filter setup register, split into its fields at reset
  localparam logic [7:0] FILT_RST = `GTD_FILT_RST;

  typedef struct packed {
    // Setup registers
    logic [`GTD_GAIN_W-1:0] gain;
    logic [1:0] fsel;
    logic [3:0] rate;
    // APB answer
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Gain stage
    logic gv;
    logic [SW-1:0] gd;
    // Decimation state
    logic [9:0] cnt;
    logic [AW-1:0] acc;
    logic [4:0][AW-1:0] integ;
    logic [4:0][AW-1:0] dly;
    logic [1:0][SW-1:0] hist;
    logic phase;
    logic [2:0] warm;
    // Output register and input throttle
    logic ov;
    logic [SW-1:0] od;
    logic in_ready;
  } st_t;

  st_t s_q, s_d;

  // ----------------------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------------------
  // Register decode: only word-aligned byte addresses whose index matches a
  // register select anything; every other address answers with an error and
  // reads as zero, so a stray write can never disturb the filter setup.
  function automatic gtd_reg_t reg_decode(input logic [`GTD_ADDR_W-1:0] a);
    gtd_reg_t r;
    r = GTD_REG_NONE;
    if (a[1:0] == 2'b00) begin
      if (a[`GTD_ADDR_W-1:2] == (`GTD_ADDR_W-2)'(`GTD_IDX_GAIN)) begin
        r = GTD_REG_GAIN;
      end else if (a[`GTD_ADDR_W-1:2] == (`GTD_ADDR_W-2)'(`GTD_IDX_FILT)) begin
        r = GTD_REG_FILT;
      end else if (a[`GTD_ADDR_W-1:2] == (`GTD_ADDR_W-2)'(`GTD_IDX_STAT)) begin
        r = GTD_REG_STAT;
      end
    end
    return r;
  endfunction

  // Log2 of N for the selected filter; out-of-range codes saturate
  // Sinc1 reaches N = 1024, sinc5 and its compensated form stop at N = 256.
  function automatic logic [3:0] dec_log2(input logic [3:0] code, input logic [1:0] sel);
    logic [3:0] lg;
    lg = 4'(code + 4'd1);
    if (sel == GTD_FILT_SINC1) begin
      if (code > 4'd9) begin
        lg = `GTD_LOG2_MAX_S1;
      end
    end else if (code > 4'd7) begin
      lg = `GTD_LOG2_MAX_S5;
    end
    return lg;
  endfunction

  // Clamp into the signed sample range instead of letting it wrap, since a
  // wrapped full-scale value would flip sign.
  function automatic logic [SW-1:0] sat(input logic signed [SW+1:0] v);
    logic [SW-1:0] r;
    r = v[SW-1:0];
    if (v > $signed({{3{1'b0}}, {(SW-1){1'b1}}})) begin
      r = {1'b0, {(SW-1){1'b1}}};
    end else if (v < $signed({{3{1'b1}}, {(SW-1){1'b0}}})) begin
      r = {1'b1, {(SW-1){1'b0}}};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // Result FIFO
  // ----------------------------------------------------------------------------
  // The FIFO decouples the bursty filter output from a drain side that may stall;
  // its fill level also throttles the converter side through sample_in_ready.
  logic fifo_in_ready;
  logic [LW:0] fifo_level;
  logic fifo_out_valid;
  logic [SW-1:0] fifo_out_data;

  gtd_fifo #(
    .WIDTH(SW),
    .DEPTH(FIFO_DEPTH),
    .AW(LW)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(s_q.ov),
    .in_ready(fifo_in_ready),
    .in_data(s_q.od),
    .out_valid(fifo_out_valid),
    .out_ready(result_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Register and gain stage
  gtd_reg_t rsel;
  logic bypass;
  logic in_fire;
  logic fs_v;
  logic [SW-1:0] fs_x;

  // Decimation
  logic [3:0] lg;
  logic [9:0] last;
  logic dec_hit;
  logic new_v;
  logic [SW-1:0] new_d;
  logic signed [`GTD_GAIN_W:0] gdiff;
  logic signed [SW+`GTD_GAIN_W:0] prod;

  // Sinc arithmetic
  logic [AW-1:0] xs;
  logic [AW-1:0] v;
  logic [AW-1:0] sum1;
  logic [SW-1:0] s5;
  logic signed [SW+3:0] fir;

  // ----------------------------------------------------------------------------
  // Pipeline timing
  // ----------------------------------------------------------------------------
  // A taken sample reaches the result port three edges later when the gain code is
  // unity: filter output register, FIFO memory, FIFO output register. Any other
  // gain code adds the multiplier register, so the port sees it one edge later.
  // Decimating filters only load the output register on the last sample of a block.
  // The integrators may wrap freely: the comb differences stay exact as long as
  // the true block sum fits the accumulator word.
  // Restart clears the decimation registers and reloads the warm-up count but leaves the output register and both setup registers alone,
  // so software writes the new selection first and pulses the sync pin after.

  always_comb begin
    s_d = s_q;
    rsel = reg_decode(paddr);
    new_v = 1'b0;
    new_d = '0;
    v = '0;
    sum1 = '0;
    s5 = '0;
    fir = '0;

    // APB: zero-wait answer in the cycle after setup
    s_d.pready = psel && !penable && !s_q.pready;
    if (psel && !penable) begin
      s_d.pslverr = (rsel == GTD_REG_NONE);
      unique case (rsel)
        GTD_REG_GAIN: s_d.prdata = {22'h00_0000, s_q.gain};
        GTD_REG_FILT: s_d.prdata = {25'h000_0000, s_q.rate, 1'b0, s_q.fsel};
        GTD_REG_STAT: s_d.prdata = {16'h0000, 4'(fifo_level), dec_log2(s_q.rate, s_q.fsel),
                                    5'h00, (s_q.gain == `GTD_GAIN_RST), s_q.fsel};
        GTD_REG_NONE: s_d.prdata = 32'h0000_0000;
      endcase
    end
    // Writes land on the access edge only, when pready is already high
    if (psel && penable && s_q.pready && pwrite) begin
      if (rsel == GTD_REG_GAIN) begin
        // Upper bits are reserved and not stored
        s_d.gain = pwdata[`GTD_GAIN_W-1:0];
      end else if (rsel == GTD_REG_FILT) begin
        s_d.rate = pwdata[`GTD_RATE_HI:`GTD_RATE_LO];
        s_d.fsel = pwdata[`GTD_FSEL_HI:`GTD_FSEL_LO];
      end
    end

    // Gain stage: unity code skips the multiplier and its register
    bypass = (s_q.gain == `GTD_GAIN_RST);
    in_fire = sample_in.valid && s_q.in_ready;
    gdiff = $signed({1'b0, s_q.gain}) - `GTD_GAIN_UNITY;
    // Step of 2^-15 per code makes 0x3FF and 0x001 land on +/-0.015594
    prod = $signed(sample_in.data) * gdiff;
    s_d.gv = in_fire && !bypass;
    s_d.gd = sat((SW+2)'($signed(sample_in.data)) +
                 (SW+2)'(prod >>> `GTD_GAIN_FRAC));
    fs_v = bypass ? in_fire : s_q.gv;
    fs_x = bypass ? sample_in.data : s_q.gd;

    // Decimation counter
    lg = dec_log2(s_q.rate, s_q.fsel);
    last = 10'((11'd1 << lg) - 11'd1);
    dec_hit = fs_v && (s_q.cnt == last);
    xs = AW'($signed(fs_x));

    unique case (gtd_fsel_t'(s_q.fsel))
      GTD_FILT_OFF: begin
        new_v = fs_v;
        new_d = fs_x;
      end
      GTD_FILT_SINC1: begin
        // Accumulate and dump: the block sum over N samples, scaled back by N
        sum1 = s_q.acc + xs;
        if (fs_v) begin
          s_d.acc = dec_hit ? '0 : sum1;
          new_v = dec_hit;
          new_d = SW'($signed(sum1) >>> lg);
        end
      end
      GTD_FILT_SINC5, GTD_FILT_COMP: begin
        // Five integrators run at the sample rate, five combs at the decimated rate
        if (fs_v) begin
          v = xs;
          for (int k = 0; k < 5; k++) begin
            v = s_q.integ[k] + v;
            s_d.integ[k] = v;
          end
          if (dec_hit) begin
            for (int k = 0; k < 5; k++) begin
              s_d.dly[k] = v;
              v = v - s_q.dly[k];
            end
            s5 = SW'($signed(v) >>> (5 * lg));
            // Comb delays start at zero, so early outputs are partial and dropped
            if (s_q.warm != '0) begin
              s_d.warm = 3'(s_q.warm - 3'd1);
            end else if (s_q.fsel == GTD_FILT_SINC5) begin
              new_v = 1'b1;
              new_d = s5;
            end else begin
              // Droop compensation taps -1, 10, -1 over 8, emitted every second output
              s_d.phase = !s_q.phase;
              fir = (SW+4)'($signed(s5)) * -(SW+4)'(1) +
                    (SW+4)'($signed(s_q.hist[0])) * (SW+4)'(10) -
                    (SW+4)'($signed(s_q.hist[1]));
              new_v = s_q.phase;
              new_d = sat((SW+2)'(fir >>> 3));
            end
            s_d.hist[1] = s_q.hist[0];
            s_d.hist[0] = s5;
          end
        end
      end
    endcase
    if (fs_v) begin
      s_d.cnt = dec_hit ? '0 : 10'(s_q.cnt + 10'd1);
    end

    // Output register feeding the FIFO
    if (new_v) begin
      s_d.ov = 1'b1;
      s_d.od = new_d;
    end else if (s_q.ov && fifo_in_ready) begin
      s_d.ov = 1'b0;
    end
    // Threshold leaves room for samples already in the pipeline
    // Four slots cover the gain register, output register and registered ready lag
    s_d.in_ready = (fifo_level <= (LW+1)'(FIFO_DEPTH - `GTD_FIFO_SLACK));

    // Filter restart on the sync pulse
    if (filter_sync) begin
      s_d.gv = 1'b0;
      s_d.cnt = '0;
      s_d.acc = '0;
      s_d.integ = '0;
      s_d.dly = '0;
      s_d.hist = '0;
      s_d.phase = 1'b0;
      s_d.warm = (s_q.fsel == GTD_FILT_COMP) ? `GTD_WARM_COMP : `GTD_WARM_S5;
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  // Every field resets to zero except the two setup registers and the warm-up
  // count, which start as if a sync pulse had just arrived with the filter off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.gain <= `GTD_GAIN_RST;
      s_q.rate <= FILT_RST[`GTD_RATE_HI:`GTD_RATE_LO];
      s_q.fsel <= FILT_RST[`GTD_FSEL_HI:`GTD_FSEL_LO];
      s_q.warm <= `GTD_WARM_S5;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Every port below is a plain register of the state or of the FIFO.
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign sample_in_ready = s_q.in_ready;
  assign result_out.valid = fifo_out_valid;
  assign result_out.data = fifo_out_data;

endmodule

`default_nettype wire

//--- bench/gtd_filter_sva.sv
// Port checker for the filter core.
// Assumes the bind below; it tracks the two setup registers from APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "gtd_cfg.svh"
module gtd_filter_sva
  import gtd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`GTD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Streams
  input wire gtd_sample_t sample_in,
  input wire logic sample_in_ready,
  input wire gtd_sample_t result_out,
  input wire logic result_out_ready
);
  logic [9:0] gain_q;
  logic [7:0] filt_q;
  logic [3:0] lg;
  wire logic wr = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_q <= 10'h200;
      filt_q <= 8'h00;
    end else if (wr && paddr == 12'h09C) begin
      gain_q <= pwdata[9:0];
    end else if (wr && paddr == 12'h0A4) begin
      filt_q <= pwdata[7:0] & 8'h7B;
    end
  end
  // Codes past a filter's limit clamp to its largest factor
  assign lg = (filt_q[1:0] == 2'h1) ? ((filt_q[6:3] > 4'h9) ? 4'hA : filt_q[6:3] + 4'h1) :
    ((filt_q[6:3] > 4'h7) ? 4'h8 : filt_q[6:3] + 4'h1);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  sequence s_take(byp);
    sample_in.valid && sample_in_ready && filt_q[1:0] == 2'h0 &&
      (gain_q == 10'h200) == byp && !result_out.valid;
  endsequence
  AST_PREADY_NEXT:
    assert property (s_setup |=> pready) else $error("no answer after setup");
  AST_PREADY_ONLY:
    assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access");
  AST_SLVERR:
    assert property (psel && penable && pready && paddr != 12'h09C && paddr != 12'h0A4 &&
      paddr != 12'h0A8 |-> pslverr) else $error("unmapped access not refused");
  AST_BYPASS_LAT:
    assert property (s_take(1'b1) ##0 result_out_ready [*3] |=> result_out.valid &&
      !$past(result_out.valid) && result_out.data == $past(sample_in.data, 3))
    else $error("bypass path latency or data");
  AST_GAIN_LAT:
    assert property (s_take(1'b0) ##0 result_out_ready [*4] |=> result_out.valid &&
      !$past(result_out.valid)) else $error("corrected path latency");
  AST_STATUS_RATE:
    assert property (s_rd(12'h0A8) ##0 filt_q[1:0] != 2'h0 |-> prdata[11:8] == lg)
    else $error("effective decimation wrong");
  AST_STATUS_SEL:
    assert property (s_rd(12'h0A8) |-> prdata[2:0] == {gain_q == 10'h200, filt_q[1:0]})
    else $error("status select or bypass wrong");
  AST_GAIN_READ:
    assert property (s_rd(12'h09C) |-> prdata == 32'(gain_q)) else $error("gain readback");
  AST_RESULT_HOLD:
    assert property (result_out.valid && !result_out_ready |=> result_out.valid &&
      $stable(result_out.data)) else $error("result dropped while stalled");
endmodule
bind gtd_filter gtd_filter_sva i_gtd_filter_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_in, .sample_in_ready, .result_out,
  .result_out_ready);
`default_nettype wire

//--- bench/gtd_stream_partner.sv
// Converter source and result sink facing the filter core.
// Assumes calls right after a rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module gtd_stream_partner
  import gtd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Converter side
  output gtd_sample_t sample_in,
  input wire logic sample_in_ready,
  // Result side
  input wire gtd_sample_t result_out,
  output logic result_out_ready,
  // Sink stall from the bench
  input wire logic stall
);
  logic [19:0] got [$];
  logic hung;
  assign result_out_ready = !stall;
  initial begin
    sample_in = '0;
    hung = 1'b0;
  end
  always @(posedge pclk) begin
    if (presetn && result_out.valid && result_out_ready) begin
      got.push_back(result_out.data);
    end
  end
  // Constant samples held until each is taken; idle data inverted so it is never reused
  task automatic burst(input logic [19:0] x, input int n);
    int t;
    t = 0;
    sample_in <= '{valid: 1'b1, data: x};
    while (n > 0 && t < 5000) begin
      @(posedge pclk);
      t++;
      if (sample_in_ready) begin
        n--;
      end
    end
    if (n > 0) begin
      hung = 1'b1;
    end
    sample_in <= '{valid: 1'b0, data: ~x};
  endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the gain trim and decimation filter core.
// Assumes the stream partner model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gtd_pkg::*;
  typedef struct {logic [9:0] g; logic [7:0] f; logic [11:0] s;} gtd_row_t;
  typedef struct {logic [7:0] f; int n; int c;} gtd_srow_t;
  // Gain, filter setup, expected status
  gtd_row_t rows [14] = '{'{10'h200, 8'h01, 12'h105}, '{10'h3FF, 8'h39, 12'h801},
    '{10'h001, 8'h41, 12'h901}, '{10'h200, 8'h49, 12'hA05}, '{10'h200, 8'h79, 12'hA05},
    '{10'h200, 8'h3A, 12'h806}, '{10'h200, 8'h42, 12'h806}, '{10'h200, 8'h1B, 12'h407},
    '{10'h200, 8'h4B, 12'h807}, '{10'h2AB, 8'h96, 12'h302}, '{10'h200, 8'h0A, 12'h206},
    '{10'h200, 8'h21, 12'h505}, '{10'h200, 8'h2B, 12'h607}, '{10'h200, 8'h31, 12'h705}};
  // Filter setup, samples sent, results expected after warm-up
  gtd_srow_t srows [6] = '{'{8'h09, 16, 4}, '{8'h02, 20, 6}, '{8'h03, 42, 8},
    '{8'h49, 2048, 2}, '{8'h79, 1024, 1}, '{8'h42, 1280, 1}};
  logic [9:0] gl [4] = '{10'h3FF, 10'h001, 10'h300, 10'h200};
  logic [19:0] yl [4] = '{20'h4_0FF8, 20'h3_F008, 20'h4_0800, 20'h4_0000};
  logic pclk, presetn, psel, penable, pwrite, filter_sync, stall, perr;
  logic pready, pslverr, sample_in_ready, result_out_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  gtd_sample_t sample_in, result_out;
  int failures, tests_run;
  gtd_filter i_gtd_filter (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .filter_sync, .sample_in, .sample_in_ready, .result_out,
    .result_out_ready);
  gtd_stream_partner i_gtd_stream_partner (.pclk, .presetn, .sample_in, .sample_in_ready,
    .result_out, .result_out_ready, .stall);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic finish_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge pclk);
    n++;
    if (n > 3000) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  // One idle edge first, so a release never meets the next setup in one time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    step(n);
    while (!pready) step(n);
    rd = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic cfg(input logic [9:0] g, input logic [7:0] f);
    apb(1'b1, 12'h09C, 32'(g));
    apb(1'b1, 12'h0A4, 32'(f));
  endtask
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (i_gtd_stream_partner.got.size() < k) step(n);
  endtask
  initial begin
    {psel, penable, pwrite, filter_sync, stall, paddr, pwdata} = '0;
    {failures, tests_run} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      cfg(rows[i].g, rows[i].f);
      apb(1'b0, 12'h09C, '0);
      chk("gain", 32'(rows[i].g), rd);
      apb(1'b0, 12'h0A4, '0);
      chk("setup", 32'(rows[i].f & 8'h7B), rd);
      apb(1'b0, 12'h0A8, '0);
      chk("status", 32'(rows[i].s), rd);
    end
    $display("test table done");
    for (int k = 0; k < 4; k++) begin
      cfg(gl[k], 8'h00);
      i_gtd_stream_partner.got.delete();
      i_gtd_stream_partner.burst(20'h4_0000, 1);
      wait_got(1);
      chk("corrected", 32'(yl[k]), 32'(i_gtd_stream_partner.got[0]));
    end
    $display("test gain done");
    foreach (srows[i]) begin
      cfg(10'h200, srows[i].f);
      filter_sync <= 1'b1;
      @(posedge pclk);
      filter_sync <= 1'b0;
      i_gtd_stream_partner.got.delete();
      i_gtd_stream_partner.burst(20'h0_1234, srows[i].n);
      repeat (40) @(posedge pclk);
      chk("count", 32'(srows[i].c), 32'(i_gtd_stream_partner.got.size()));
      foreach (i_gtd_stream_partner.got[j]) begin
        chk("average", 32'h0000_1234, 32'(i_gtd_stream_partner.got[j]));
      end
    end
    $display("test decimation done");
    cfg(10'h200, 8'h09);
    i_gtd_stream_partner.burst(20'h0_5555, 2);
    filter_sync <= 1'b1;
    @(posedge pclk);
    filter_sync <= 1'b0;
    i_gtd_stream_partner.got.delete();
    i_gtd_stream_partner.burst(20'h0_0123, 4);
    wait_got(1);
    chk("after sync", 32'h0000_0123, 32'(i_gtd_stream_partner.got[0]));
    apb(1'b1, 12'h100, 32'h0000_0001);
    chk("unmapped err", 32'h1, 32'(perr));
    apb(1'b0, 12'h09D, '0);
    chk("misaligned", 32'h0000_0001, 32'(perr));
    $display("test sync and map done");
    cfg(10'h200, 8'h00);
    stall <= 1'b1;
    i_gtd_stream_partner.got.delete();
    fork
      i_gtd_stream_partner.burst(20'h0_0ABC, 12);
    join_none
    repeat (30) @(posedge pclk);
    chk("in ready", 32'h0, 32'(sample_in_ready));
    stall <= 1'b0;
    wait_got(12);
    repeat (10) @(posedge pclk);
    chk("drained", 32'h0, 32'(result_out.valid));
    chk("hung", 32'h0, 32'(i_gtd_stream_partner.hung));
    $display("test buffer done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h09C, '0);
    chk("gain reset", 32'h0000_0200, rd);
    apb(1'b0, 12'h0A4, '0);
    chk("setup reset", 32'h0, rd);
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire
